// ---- core/dmac_top.sv ----
// Purpose: Four-unit multiplier block with adder and accumulator stages
// Assumes: Controls come from fabric logic on mclk
// Notes: Group clears act synchronously; only rstn is asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "dmac_map.svh"
module dmac_top (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [3:0] clockEnableGroup,
    input wire logic [3:0] clearGroup,
    input wire logic [3:0][`DMAC_OPD_W-1:0] dataA,
    input wire logic [3:0][`DMAC_OPD_W-1:0] dataB,
    input wire logic [3:0] sourceA,
    input wire logic [3:0] sourceB,
    input wire logic [`DMAC_OPD_W-1:0] shiftInA,
    input wire logic [`DMAC_OPD_W-1:0] shiftInB,
    input wire logic signA,
    input wire logic signB,
    input wire logic wide36Mode,
    input wire logic [1:0] halfUpperOperationSelect,
    input wire logic [1:0] halfLowerOperationSelect,
    input wire logic halfUpperSize9,
    input wire logic halfLowerSize9,
    input wire logic addSubtractSelectUpper,
    input wire logic addSubtractSelectLower,
    input wire logic adderRoundEnableUpper,
    input wire logic adderRoundEnableLower,
    input wire logic pairLowProductRound,
    input wire logic pairHighProductRound,
    input wire logic pairLowProductSaturate,
    input wire logic pairHighProductSaturate,
    input wire logic [1:0] accumRound,
    input wire logic [1:0] accumSaturate,
    input wire logic [1:0] accumSyncLoad,
    output logic [3:0][`DMAC_ROW_W-1:0] rowOut,
    output logic [`DMAC_OPD_W-1:0] shiftOutA,
    output logic [`DMAC_OPD_W-1:0] shiftOutB
);
    dmac_pkg::dmac_top_state_t s_reg;
    dmac_pkg::dmac_top_state_t s_next;
    dmac_pkg::dmac_op_t opH [2];
    logic [1:0] size9H;
    logic [1:0] addH;
    logic [1:0] adderRnd;
    logic [1:0] pairRnd;
    logic [1:0] pairSat;
    logic [3:0][`DMAC_OPD_W-1:0] regA;
    logic [3:0][`DMAC_OPD_W-1:0] regB;
    logic [3:0][`DMAC_ROW_W-1:0] prodU;
    logic [3:0][`DMAC_ROW_W-1:0] rowVal;
    logic [1:0][`DMAC_ACC_W-1:0] accVal;
    logic signed [52:0] xs [4];
    logic signed [52:0] loSum [2];
    logic signed [52:0] hiSum [2];
    logic signed [52:0] t;
    logic [72:0] wideSum;

    assign opH[0] = dmac_pkg::dmac_op_t'(halfUpperOperationSelect);
    assign opH[1] = dmac_pkg::dmac_op_t'(halfLowerOperationSelect);
    assign size9H = {halfLowerSize9, halfUpperSize9};
    assign addH = {addSubtractSelectLower, addSubtractSelectUpper};
    assign adderRnd = {adderRoundEnableLower, adderRoundEnableUpper};
    assign pairRnd = {pairHighProductRound, pairLowProductRound};
    assign pairSat = {pairHighProductSaturate, pairLowProductSaturate};

    // ----------------------------------------------------------------
    // Arithmetic helpers
    // ----------------------------------------------------------------
    function automatic logic signed [52:0] sx36(input logic [35:0] v);
        sx36 = $signed({{17{v[35]}}, v});
    endfunction : sx36

    function automatic logic signed [52:0] sx18(input logic [17:0] v);
        sx18 = $signed({{35{v[17]}}, v});
    endfunction : sx18

    function automatic logic signed [52:0] addsub(
        input logic signed [52:0] x, input logic signed [52:0] y,
        input logic add);
        addsub = add ? x + y : x - y;
    endfunction : addsub

    // Round to 15 fraction bits, then clamp into Q1.15 range
    function automatic logic signed [52:0] qfix(
        input logic signed [52:0] v, input logic rnd, input logic sat);
        logic signed [52:0] r;
        r = rnd ? v + $signed(`DMAC_ROUND_ADD) : v;
        if (rnd) begin
            r = r & $signed(`DMAC_FRAC_MASK);
        end
        if (sat && r > $signed(`DMAC_Q_MAX)) begin
            r = $signed(`DMAC_Q_MAX);
        end else if (sat && r < $signed(`DMAC_Q_MIN)) begin
            r = $signed(`DMAC_Q_MIN);
        end
        qfix = r;
    endfunction : qfix

    // ----------------------------------------------------------------
    // Units and shift chain
    // ----------------------------------------------------------------
    for (genvar i = 0; i < 4; i++) begin : g_unit
        // 36-bit mode feeds four partial products from rows 0 and 1
        dmac_unit u_unit (
            .mclk(mclk),
            .rstn(rstn),
            .enable(clockEnableGroup[i]),
            .clear(clearGroup[i]),
            .size9(size9H[i/2] & ~wide36Mode),
            .signA(signA & (~wide36Mode | (i % 2 == 1))),
            .signB(signB & (~wide36Mode | (i >= 2))),
            .selChainA(sourceA[i] & ~wide36Mode),
            .selChainB(sourceB[i] & ~wide36Mode),
            .dataA(wide36Mode ? dataA[i%2] : dataA[i]),
            .dataB(wide36Mode ? dataB[i/2] : dataB[i]),
            .chainA(i == 0 ? shiftInA : regA[(i+3)%4]),
            .chainB(i == 0 ? shiftInB : regB[(i+3)%4]),
            .regA(regA[i]),
            .regB(regB[i]),
            .product(prodU[i])
        );
    end

    // Chain leaves the block for the next block or column
    assign shiftOutA = regA[3];
    assign shiftOutB = regB[3];

    // ----------------------------------------------------------------
    // Post-multiplier stage
    // ----------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        rowVal = '0;
        accVal = s_reg.acc;
        t = '0;
        for (int i = 0; i < 4; i++) begin
            xs[i] = sx36(prodU[i]);
        end
        for (int h = 0; h < 2; h++) begin
            loSum[h] = addsub(sx18(prodU[2*h][17:0]),
                sx18(prodU[2*h+1][17:0]), addH[h]);
            hiSum[h] = addsub(sx18(prodU[2*h][35:18]),
                sx18(prodU[2*h+1][35:18]), addH[h]);
            case (opH[h])
                dmac_pkg::DMAC_OP_SIMPLE: begin
                    for (int k = 0; k < 2; k++) begin
                        t = qfix(xs[2*h+k], pairRnd[h] & ~size9H[h],
                            pairSat[h] & ~size9H[h]);
                        rowVal[2*h+k] = t[35:0];
                    end
                end
                dmac_pkg::DMAC_OP_MAC: begin
                    // Accumulation exists only at the 18-bit size
                    if (size9H[h]) begin
                        rowVal[2*h] = prodU[2*h];
                        rowVal[2*h+1] = prodU[2*h+1];
                    end else begin
                        t = addsub($signed({s_reg.acc[h][51],
                            s_reg.acc[h]}), xs[2*h], addH[h]);
                        accVal[h] = accumSyncLoad[h] ? xs[2*h][51:0]
                            : t[51:0];
                        t = qfix($signed({accVal[h][51], accVal[h]}),
                            accumRound[h], accumSaturate[h]);
                        rowVal[2*h] = t[35:0];
                        rowVal[2*h+1] = {{20{t[51]}}, t[51:36]};
                    end
                end
                dmac_pkg::DMAC_OP_ADD2: begin
                    if (size9H[h]) begin
                        rowVal[2*h] = loSum[h][35:0];
                        rowVal[2*h+1] = hiSum[h][35:0];
                    end else begin
                        t = qfix(addsub(xs[2*h], xs[2*h+1], addH[h]),
                            adderRnd[h], pairSat[h]);
                        rowVal[2*h] = t[35:0];
                    end
                end
                default: begin
                    rowVal[2*h] = '0;
                end
            endcase
        end
        // Four-product sum is steered by the upper half select
        if (opH[0] == dmac_pkg::DMAC_OP_ADD4) begin
            rowVal = '0;
            if (size9H[0]) begin
                t = loSum[0] + loSum[1];
                rowVal[0] = t[35:0];
                t = hiSum[0] + hiSum[1];
                rowVal[1] = t[35:0];
            end else begin
                t = qfix(addsub(xs[0], xs[1], addH[0])
                    + addsub(xs[2], xs[3], addH[1]),
                    adderRnd[0], pairSat[0]);
                rowVal[0] = t[35:0];
            end
        end
        wideSum = ({{37{prodU[3][35]}}, prodU[3]} << `DMAC_WIDE_HI)
            + ({{37{prodU[1][35]}}, prodU[1]} << `DMAC_WIDE_LO)
            + ({{37{prodU[2][35]}}, prodU[2]} << `DMAC_WIDE_LO)
            + {37'h0, prodU[0]};
        if (wide36Mode) begin
            // No adder here: fabric adds or accumulates wide products
            rowVal = {72'h0, wideSum[71:0]};
            accVal = s_reg.acc;
        end
        for (int i = 0; i < 4; i++) begin
            if (clearGroup[i]) begin
                s_next.row[i] = '0;
            end else if (clockEnableGroup[i]) begin
                s_next.row[i] = rowVal[i];
            end
        end
        for (int h = 0; h < 2; h++) begin
            if (clearGroup[2*h+1]) begin
                s_next.acc[h] = '0;
            end else if (clockEnableGroup[2*h+1]) begin
                s_next.acc[h] = accVal[h];
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Low 18 bits go left, high 18 right; all reach routing
    assign rowOut = s_reg.row;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    logic upSimple18;
    logic loAdd18;
    logic upMac18;
    assign upSimple18 = opH[0] == dmac_pkg::DMAC_OP_SIMPLE
        && !halfUpperSize9 && !wide36Mode
        && clockEnableGroup[0] && !clearGroup[0];
    assign loAdd18 = opH[1] == dmac_pkg::DMAC_OP_ADD2 && !halfLowerSize9
        && opH[0] != dmac_pkg::DMAC_OP_ADD4 && !wide36Mode
        && clockEnableGroup[2] && !clearGroup[2];
    assign upMac18 = opH[0] == dmac_pkg::DMAC_OP_MAC && !halfUpperSize9
        && !wide36Mode && clockEnableGroup[1] && !clearGroup[1];

    a_wide_rows_zero: assert property (wide36Mode && clockEnableGroup[2]
        && !clearGroup[2] |=> rowOut[2] == '0)
        else $error("wide mode left adder output in row 2");
    a_sload_loads: assert property (upMac18 && accumSyncLoad[0]
        |=> s_reg.acc[0] == $past(xs[0][51:0]))
        else $error("sync load did not take product");
    a_mac_adds: assert property (upMac18 && !accumSyncLoad[0]
        && addSubtractSelectUpper |=> s_reg.acc[0]
        == $past(s_reg.acc[0]) + $past(xs[0][51:0]))
        else $error("accumulator did not add product");
    a_group_clear: assert property (clearGroup[1]
        |=> rowOut[1] == '0 && s_reg.acc[0] == '0)
        else $error("group clear ignored");
    a_group_hold: assert property (!clockEnableGroup[3] && !clearGroup[3]
        |=> $stable(rowOut[3]))
        else $error("disabled group changed");
    a_round_frac: assert property (upSimple18 && pairLowProductRound
        |=> rowOut[0][14:0] == 15'h0000)
        else $error("rounded product keeps fraction bits");
    a_sat_bound: assert property (upSimple18 && pairLowProductSaturate
        |=> $signed(rowOut[0]) <= $signed(36'h03FFFFFFF))
        else $error("saturated product above range");
    a_two_add: assert property (loAdd18 && addSubtractSelectLower
        && !adderRoundEnableLower && !pairHighProductSaturate
        |=> rowOut[2] == $past(prodU[2] + prodU[3]))
        else $error("two-product sum wrong");
    a_mixed_small: assert property (opH[1] == dmac_pkg::DMAC_OP_SIMPLE
        && halfLowerSize9 && !wide36Mode && opH[0] != dmac_pkg::DMAC_OP_ADD4
        && clockEnableGroup[3] && !clearGroup[3]
        |=> rowOut[3] == $past(prodU[3]))
        else $error("small simple half altered product");

    c_mac_run: cover property (upMac18 [*3]);
    c_wide_mode: cover property (wide36Mode && clockEnableGroup[0]);
    c_four_add: cover property (opH[0] == dmac_pkg::DMAC_OP_ADD4
        && clockEnableGroup[0]);
    c_mixed: cover property (upMac18 && halfLowerSize9);
endmodule : dmac_top
`default_nettype wire

// ---- core/dmac_unit.sv ----
// Purpose: One 18x18 multiplier unit with input shift registers
// Assumes: Same clock as the surrounding fabric
// Notes: Two-stage pipe: operands, then product
`timescale 1ns/1ps
`default_nettype none
`include "dmac_map.svh"
module dmac_unit (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic enable,
    input wire logic clear,
    input wire logic size9,
    input wire logic signA,
    input wire logic signB,
    input wire logic selChainA,
    input wire logic selChainB,
    input wire logic [`DMAC_OPD_W-1:0] dataA,
    input wire logic [`DMAC_OPD_W-1:0] dataB,
    input wire logic [`DMAC_OPD_W-1:0] chainA,
    input wire logic [`DMAC_OPD_W-1:0] chainB,
    output logic [`DMAC_OPD_W-1:0] regA,
    output logic [`DMAC_OPD_W-1:0] regB,
    output logic [`DMAC_ROW_W-1:0] product
);
    dmac_pkg::dmac_unit_state_t s_reg;
    dmac_pkg::dmac_unit_state_t s_next;
    logic signed [37:0] prodFull;
    logic signed [19:0] prodLo;
    logic signed [19:0] prodHi;

    // ----------------------------------------------------------------
    // Operand capture and multiply
    // ----------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        prodFull = $signed({signA & s_reg.a[17], s_reg.a})
            * $signed({signB & s_reg.b[17], s_reg.b});
        prodLo = $signed({signA & s_reg.a[8], s_reg.a[8:0]})
            * $signed({signB & s_reg.b[8], s_reg.b[8:0]});
        prodHi = $signed({signA & s_reg.a[17], s_reg.a[17:9]})
            * $signed({signB & s_reg.b[17], s_reg.b[17:9]});
        if (clear) begin
            s_next = '0;
        end else if (enable) begin
            s_next.a = selChainA ? chainA : dataA;
            s_next.b = selChainB ? chainB : dataB;
            // Two 9x9 products share the unit in the small size
            s_next.p = size9 ? {prodHi[17:0], prodLo[17:0]}
                : prodFull[35:0];
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign regA = s_reg.a;
    assign regB = s_reg.b;
    assign product = s_reg.p;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_chain_load: assert property (@(posedge mclk) disable iff (!rstn)
        selChainA && enable && !clear |=> regA == $past(chainA))
        else $error("chain operand not captured");
    a_direct_load: assert property (@(posedge mclk) disable iff (!rstn)
        !selChainB && enable && !clear |=> regB == $past(dataB))
        else $error("direct operand not captured");
    c_chain_used: cover property (@(posedge mclk) disable iff (!rstn)
        selChainA && enable);
endmodule : dmac_unit
`default_nettype wire

// ---- inc/dmac_map.svh ----
// Purpose: Constants for the multiply-accumulate block
// Assumes: Included by its bare name from package and modules
// Notes: Definitions only
`ifndef DMAC_MAP_SVH
`define DMAC_MAP_SVH
// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define DMAC_OPD_W 18
`define DMAC_ROW_W 36
`define DMAC_ACC_W 52
`define DMAC_WIDE_LO 18
`define DMAC_WIDE_HI 36
// ----------------------------------------------------------------
// Q1.15 fixed point on a 53-bit working value
// ----------------------------------------------------------------
`define DMAC_ROUND_ADD 53'h0000000004000
`define DMAC_FRAC_MASK 53'h1FFFFFFFFF8000
`define DMAC_Q_MAX 53'h000003FFFFFFF
`define DMAC_Q_MIN 53'h1FFFFFC0000000
`endif

// ---- inc/dmac_pkg.sv ----
// Purpose: Types for the multiply-accumulate block
// Assumes: dmac_map.svh present on the include path
// Notes: Mode codes follow the operation select inputs
`include "dmac_map.svh"
package dmac_pkg;
    typedef enum logic [1:0] {
        DMAC_OP_SIMPLE = 2'b00,
        DMAC_OP_MAC = 2'b01,
        DMAC_OP_ADD2 = 2'b10,
        DMAC_OP_ADD4 = 2'b11
    } dmac_op_t;

    typedef struct packed {
        logic [`DMAC_OPD_W-1:0] a;
        logic [`DMAC_OPD_W-1:0] b;
        logic [`DMAC_ROW_W-1:0] p;
    } dmac_unit_state_t;

    typedef struct packed {
        logic [1:0][`DMAC_ACC_W-1:0] acc;
        logic [3:0][`DMAC_ROW_W-1:0] row;
    } dmac_top_state_t;
endpackage : dmac_pkg

// ---- verification/dmac_fabric_model.sv ----
// Purpose: Fabric-side source of the block's input shift chain
// Assumes: Shares mclk with the block
// Notes: Stands in for the upstream block of a long filter
`timescale 1ns/1ps
`default_nettype none
module dmac_fabric_model (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic run,
    output logic [17:0] shiftInA,
    output logic [17:0] shiftInB
);
    logic [17:0] countReg;

    // Falling edge, so the block samples settled chain data
    always_ff @(negedge mclk or negedge rstn) begin
        if (!rstn) begin
            countReg <= 18'h00000;
        end else if (run) begin
            countReg <= countReg + 18'h00001;
        end else begin
            // Idle chain toggles so a stale value never looks valid
            countReg <= ~countReg;
        end
    end

    assign shiftInA = countReg;
    assign shiftInB = ~countReg;
endmodule : dmac_fabric_model

`default_nettype wire

// ---- verification/dmac_top_tb_top.sv ----
// Purpose: Self-checking bench for the multiply-accumulate block
// Assumes: Controls held steady while results settle
// Notes: Expected values worked out by hand from the mode rules
`timescale 1ns/1ps
`default_nettype none
module dmac_top_tb_top;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic run;
    logic [3:0] en, clr, srcA, srcB;
    logic [3:0][17:0] dA, dB;
    logic sgA, sgB, wide, upS9, loS9, asUp, asLo, arUp, arLo;
    logic loRnd, hiRnd, loSat, hiSat;
    logic [1:0] upOp, loOp, acRnd, acSat, acLd;
    logic [3:0][35:0] row;
    logic [17:0] shA, shB, soA, soB;
    int mismatches = 0;
    int samples_checked = 0;

    always #12.5 mclk = ~mclk;

    dmac_top DUT (
        .mclk(mclk),
        .rstn(rstn),
        .clockEnableGroup(en),
        .clearGroup(clr),
        .dataA(dA),
        .dataB(dB),
        .sourceA(srcA),
        .sourceB(srcB),
        .shiftInA(shA),
        .shiftInB(shB),
        .signA(sgA),
        .signB(sgB),
        .wide36Mode(wide),
        .halfUpperOperationSelect(upOp),
        .halfLowerOperationSelect(loOp),
        .halfUpperSize9(upS9),
        .halfLowerSize9(loS9),
        .addSubtractSelectUpper(asUp),
        .addSubtractSelectLower(asLo),
        .adderRoundEnableUpper(arUp),
        .adderRoundEnableLower(arLo),
        .pairLowProductRound(loRnd),
        .pairHighProductRound(hiRnd),
        .pairLowProductSaturate(loSat),
        .pairHighProductSaturate(hiSat),
        .accumRound(acRnd),
        .accumSaturate(acSat),
        .accumSyncLoad(acLd),
        .rowOut(row),
        .shiftOutA(soA),
        .shiftOutB(soB)
    );

    dmac_fabric_model fabric (
        .mclk(mclk),
        .rstn(rstn),
        .run(run),
        .shiftInA(shA),
        .shiftInB(shB)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [143:0] seen,
            input logic [143:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic conclude;
        $display("Comparisons %0d mismatches %0d", samples_checked,
            mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    task automatic quiet;
        {sgA, sgB, wide, upS9, loS9, asUp, asLo, arUp, arLo} = '0;
        {loRnd, hiRnd, loSat, hiSat, upOp, loOp, acRnd, acSat, acLd} = '0;
        {clr, srcA, srcB, dA, dB, run} = '0;
        en = 4'hF;
    endtask : quiet

    // Static operands, so one edge of slack past the pipe is harmless
    task automatic settle;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
    endtask : settle

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        check("rows after reset", row, 144'h0);
        check("chain after reset", {soA, soB}, 144'h0);
        $display("reset test done");
    endtask : t_reset

    task automatic t_simple;
        logic [143:0] e;
        quiet();
        {sgA, sgB} = 2'h3;
        dA = {18'h1FFFF, 18'h00100, 18'h00007, 18'h3FFFD};
        dB = {18'h00002, 18'h00020, 18'h3FFFF, 18'h00005};
        settle();
        e = {36'h3FFFE, 36'h2000, 36'hFFFFFFFF9, 36'hFFFFFFFF1};
        check("signed rows", row, e);
        {sgA, sgB} = 2'h0;
        dA[0] = 18'h3FFFF;
        dB[0] = 18'h3FFFF;
        settle();
        check("unsigned row", row[0], 144'hFFFF80001);
        $display("simple test done");
    endtask : t_simple

    task automatic t_qfix;
        logic [143:0] e;
        quiet();
        {sgA, sgB} = 2'h3;
        {loRnd, loSat} = 2'h3;
        dA = {18'h00001, 18'h20000, 18'h00001, 18'h20000};
        dB = {18'h04000, 18'h1FFFF, 18'h04000, 18'h1FFFF};
        settle();
        e = {36'h4000, 36'hC00020000, 36'h8000, 36'hFC0000000};
        check("q15 rows", row, e);
        $display("round and saturate test done");
    endtask : t_qfix

    task automatic t_adders;
        quiet();
        upOp = 2'h2;
        loOp = 2'h2;
        asUp = 1'b1;
        dA = {18'h2, 18'h7, 18'h5, 18'h3};
        dB = {18'h3, 18'h8, 18'h6, 18'h4};
        settle();
        check("two-add 18", row, {36'h0, 36'h32, 36'h0, 36'h2A});
        upOp = 2'h3;
        loOp = 2'h3;
        asLo = 1'b1;
        settle();
        check("four-add 18", row, 144'h68);
        upOp = 2'h2;
        loOp = 2'h0;
        upS9 = 1'b1;
        dA[1:0] = {18'h00201, 18'h00403};
        dB[1:0] = {18'h00C07, 18'h00805};
        settle();
        check("two-add 9", row[1:0], {36'hE, 36'h16});
        $display("adder test done");
    endtask : t_adders

    task automatic t_mixed;
        logic [143:0] e;
        quiet();
        upOp = 2'h1;
        asUp = 1'b1;
        acLd = 2'h1;
        loS9 = 1'b1;
        dA = {18'h0, 18'h00604, 18'h0, 18'h00100};
        dB = {18'h0, 18'h00A06, 18'h0, 18'h00003};
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        acLd = 2'h0;
        // Exactly three summing edges, then the accumulator is frozen
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        // Row 0 keeps showing sum plus product unless its group stops too
        en[1:0] = 2'h0;
        settle();
        e = {36'h0, 36'h3C0018, 36'h0, 36'hC00};
        check("mac and 9-bit rows", row, e);
        $display("mixed mode test done");
    endtask : t_mixed

    task automatic t_groups;
        quiet();
        dA = {18'h4, 18'h3, 18'h2, 18'h1};
        dB = {4{18'h2}};
        settle();
        en[3:2] = 2'h0;
        clr[1] = 1'b1;
        dB = {4{18'h5}};
        settle();
        check("group rows", row, {36'h8, 36'h6, 36'h0, 36'h5});
        // Clear must win even while its group is disabled
        clr = 4'h8;
        en[2] = 1'b1;
        settle();
        check("clear over hold", row, {36'h0, 36'hF, 36'hA, 36'h5});
        $display("group test done");
    endtask : t_groups

    task automatic t_wide;
        quiet();
        wide = 1'b1;
        dA = {36'h0, 18'h1, 18'h1};
        dB = {36'h0, 18'h1, 18'h3};
        settle();
        check("wide rows", row, {72'h0, 72'h1000100003});
        $display("wide test done");
    endtask : t_wide

    task automatic t_extras;
        logic [143:0] e;
        quiet();
        {upOp, loOp} = 4'hA;
        {asUp, asLo, arUp} = 3'h7;
        dA = {18'h00007, 18'h00005, 18'h01000, 18'h03000};
        dB = {18'h00002, 18'h00006, 18'h00001, 18'h00001};
        settle();
        e = {36'h0, 36'h2C, 36'h0, 36'h8000};
        check("rounded two-add", row, e);
        {upOp, loOp} = 4'hF;
        {upS9, loS9, arUp} = 3'h6;
        dA = {18'h00201, 18'h00602, 18'h00201, 18'h00403};
        dB = {18'h00201, 18'h00402, 18'h00C07, 18'h00805};
        settle();
        e = {36'h0, 36'h0, 36'h15, 36'h1B};
        check("four-add 9", row, e);
        {upOp, loOp} = 4'h1;
        {upS9, loS9, asLo} = 3'h0;
        {acLd, acRnd, acSat} = 6'h2A;
        dA[2] = 18'h06000;
        dB[2] = 18'h00001;
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        acLd = 2'h0;
        // Two subtracting edges turn the loaded product negative
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        en[3:2] = 2'h0;
        settle();
        e = {72'h0, 36'hFFFFFFFFF, 36'hFFFFF8000};
        check("lower accumulate", row[3:2], e);
        $display("extra modes test done");
    endtask : t_extras

    task automatic t_chain;
        int k;
        quiet();
        srcA = 4'hF;
        srcB = 4'hF;
        run = 1'b1;
        repeat (6) @(posedge mclk);
        for (k = 0; k < 3; k++) begin
            @(posedge mclk);
            #5;
            check("chain A", soA, 18'(shA - 18'h3));
            check("chain B", soB, 18'(shB + 18'h3));
        end
        @(negedge mclk);
        run = 1'b0;
        $display("chain test done");
    endtask : t_chain

    initial begin
        quiet();
        repeat (16) @(posedge mclk);
        @(negedge mclk);
        rstn = 1'b1;
        t_reset();
        t_simple();
        t_qfix();
        t_adders();
        t_mixed();
        t_groups();
        t_wide();
        t_extras();
        t_chain();
        conclude();
    end

    // Whole run is under 150 cycles; twenty times that means a hang
    initial begin
        repeat (3000) @(posedge mclk);
        mismatches++;
        conclude();
    end
endmodule : dmac_top_tb_top

`default_nettype wire
